// file: common/pcitgt_cfg.svh
// Purpose: constants shared by both ends of the target link
// Assumes: 32-bit multiplexed bus, one window
// Notes:   included by bare name
`ifndef PCITGT_CFG_SVH
`define PCITGT_CFG_SVH
`define PCITGT_CMD_DAC   4'hD
`define PCITGT_CMD_MRD   4'h6
`define PCITGT_CMD_MWR   4'h7
`define PCITGT_CMD_MRM   4'hC
`define PCITGT_CMD_MRL   4'hE
`define PCITGT_CMD_MWI   4'hF
`define PCITGT_BE_ALL    4'h0
`define PCITGT_CBE_IDLE  4'hF
`define PCITGT_AD_PULLUP 32'hFFFF_FFFF
`define PCITGT_AD_RST    32'h0000_0000
`define PCITGT_HI_ZERO   32'h0000_0000
`define PCITGT_ABORT_CLK 3'h5
`endif

// file: common/pcitgt_pkg.sv
// Purpose: types shared by both ends of the target link
// Assumes: nothing beyond the cfg header
// Notes:   state codes are one-hot
package pcitgt_pkg;
  typedef enum logic [1:0]
  {
    PCITGT_SPD_FAST   = 2'h0,
    PCITGT_SPD_MEDIUM = 2'h1,
    PCITGT_SPD_SLOW   = 2'h2
  } pcitgt_speed_e;

  typedef enum logic [4:0]
  {
    PCITGT_T_IDLE   = 5'h01,
    PCITGT_T_ADDR2  = 5'h02,
    PCITGT_T_DECODE = 5'h04,
    PCITGT_T_SEL    = 5'h08,
    PCITGT_T_DONE   = 5'h10
  } pcitgt_tstate_e;

  typedef enum logic [4:0]
  {
    PCITGT_M_IDLE  = 5'h01,
    PCITGT_M_ADDR  = 5'h02,
    PCITGT_M_ADDR2 = 5'h04,
    PCITGT_M_DATA  = 5'h08,
    PCITGT_M_TURN  = 5'h10
  } pcitgt_mstate_e;
endpackage

// file: common/pcitgt_if.sv
// Purpose: bus and back-end wires between target and its partner
// Assumes: one clock shared by both ends
// Notes:   shared lines resolve from enables, idle level is high
`timescale 1ns/1ps
`include "pcitgt_cfg.svh"
interface pcitgt_if;
  // Partner drives
  logic        m_frame_n;
  logic        m_irdy_n;
  logic [3:0]  m_cbe_n;
  logic [31:0] m_ad;
  logic        m_ctl_oe_n;
  logic        m_irdy_oe_n;
  logic        m_ad_oe_n;
  logic        backend_ready_n;
  logic [31:0] local_read_data;
  // Target drives
  logic        t_devsel_n;
  logic        t_trdy_n;
  logic        t_ctl_oe_n;
  logic [31:0] t_ad;
  logic        t_ad_oe_n;
  logic [63:0] local_addr_out;
  logic        win_hit;
  logic        local_xfer_strobe_n;
  logic [31:0] local_write_data;
  // Resolved bus lines
  logic        framen;
  logic        irdyn;
  logic [3:0]  cben;
  logic        devseln;
  logic        trdyn;
  logic [31:0] ad;

  assign framen  = m_ctl_oe_n ? 1'h1 : m_frame_n;
  assign irdyn   = m_irdy_oe_n ? 1'h1 : m_irdy_n;
  assign cben    = m_ctl_oe_n ? `PCITGT_CBE_IDLE : m_cbe_n;
  assign devseln = t_ctl_oe_n ? 1'h1 : t_devsel_n;
  assign trdyn   = t_ctl_oe_n ? 1'h1 : t_trdy_n;
  assign ad      = !t_ad_oe_n ? t_ad :
                   (!m_ad_oe_n ? m_ad : `PCITGT_AD_PULLUP);

  modport target
  (
    input  framen, irdyn, cben, ad, backend_ready_n, local_read_data,
    output t_devsel_n, t_trdy_n, t_ctl_oe_n, t_ad, t_ad_oe_n,
    output local_addr_out, win_hit, local_xfer_strobe_n,
    output local_write_data
  );

  modport partner
  (
    input  devseln, trdyn, ad, local_addr_out, win_hit,
    input  local_xfer_strobe_n, local_write_data,
    output m_frame_n, m_irdy_n, m_cbe_n, m_ad, m_ctl_oe_n,
    output m_irdy_oe_n, m_ad_oe_n, backend_ready_n, local_read_data
  );
endinterface

// file: rtl/pcitgt_target.sv
// Purpose: target sequencing with dual address and back-to-back
// Assumes: single bus clock, 32-bit bus, one memory window
// Notes:   master must hold irdyn once asserted on reads
`timescale 1ns/1ps
`include "pcitgt_cfg.svh"
module pcitgt_target
#(
  parameter logic [63:0] WIN_BASE = 64'h0000_0001_0000_0000,
  parameter logic [63:0] WIN_MASK = 64'hFFFF_FFFF_FFF0_0000
)
(
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // Configuration
  input  wire pcitgt_pkg::pcitgt_speed_e select_response_speed_i,
  // Bus and back-end
  pcitgt_if.target                       bus
);

  if ((WIN_BASE & ~WIN_MASK) != 64'h0)
  begin : g_chk
    $error("window base has bits below the mask");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_read(input logic [3:0] c);
    is_read = (c == `PCITGT_CMD_MRD) || (c == `PCITGT_CMD_MRM) ||
              (c == `PCITGT_CMD_MRL);
  endfunction

  function automatic logic win_match(input logic [63:0] a,
                                     input logic [3:0]  c);
    logic mem;
    mem = is_read(c) || (c == `PCITGT_CMD_MWR) ||
          (c == `PCITGT_CMD_MWI);
    win_match = mem && ((a & WIN_MASK) == WIN_BASE);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pcitgt_pkg::pcitgt_tstate_e st_q, st_d;
  logic        frm_q, frm_d;
  logic [31:0] lo_q, lo_d;
  logic        sel_q, sel_d;
  logic        rd_q, rd_d;
  logic        dev_q, dev_d;
  logic        trdy_q, trdy_d;
  logic        xfer_q, xfer_d;
  logic        rdy1_q, rdy1_d;
  logic        oe_q, oe_d;
  logic        ad_oe_q, ad_oe_d;
  logic [31:0] ad_q, ad_d;
  logic [31:0] wdat_q, wdat_d;
  logic [63:0] laddr_q, laddr_d;
  logic        win_q, win_d;
  logic        addr_start;
  logic        fin;
  logic        done_ph;
  logic        stall;
  logic        ready;
  logic        slow;
  logic        fast;
  logic [63:0] fa;

  always_comb
  begin
    st_d    = st_q;
    frm_d   = bus.framen;
    lo_d    = lo_q;
    sel_d   = sel_q;
    rd_d    = rd_q;
    dev_d   = dev_q;
    trdy_d  = trdy_q;
    xfer_d  = 1'h0;
    oe_d    = oe_q;
    ad_oe_d = ad_oe_q;
    ad_d    = ad_q;
    wdat_d  = wdat_q;
    laddr_d = laddr_q;
    win_d   = win_q;
    slow    = select_response_speed_i == pcitgt_pkg::PCITGT_SPD_SLOW;
    fast    = select_response_speed_i == pcitgt_pkg::PCITGT_SPD_FAST;
    // Address phase: framen falls after a clock with it high
    addr_start = !bus.framen && frm_q;
    done_ph = trdy_q && !bus.irdyn && bus.framen;
    stall   = trdy_q && bus.irdyn;
    ready   = !bus.backend_ready_n &&
              (st_q == pcitgt_pkg::PCITGT_T_SEL);
    rdy1_d  = ready;
    fin     = 1'h0;
    fa      = {`PCITGT_HI_ZERO, bus.ad};
    case (st_q)
      pcitgt_pkg::PCITGT_T_IDLE,
      pcitgt_pkg::PCITGT_T_DONE:
      begin
        // Turnaround clock is over: float the controls
        oe_d = 1'h0;
        st_d = pcitgt_pkg::PCITGT_T_IDLE;
        if (addr_start)
        begin
          // Fresh address, also straight after a final phase
          if (bus.cben == `PCITGT_CMD_DAC)
          begin
            lo_d = bus.ad;
            st_d = pcitgt_pkg::PCITGT_T_ADDR2;
          end
          else
          begin
            fin = 1'h1;
          end
        end
      end
      pcitgt_pkg::PCITGT_T_ADDR2:
      begin
        // Upper half on the second phase; bus width is no limit
        fin = 1'h1;
        fa  = {bus.ad, lo_q};
      end
      pcitgt_pkg::PCITGT_T_DECODE:
      begin
        win_d = sel_q;
        if (sel_q)
        begin
          st_d = pcitgt_pkg::PCITGT_T_SEL;
          if (!slow)
          begin
            dev_d = 1'h1;
            oe_d  = 1'h1;
          end
        end
        else
        begin
          st_d = pcitgt_pkg::PCITGT_T_IDLE;
        end
      end
      pcitgt_pkg::PCITGT_T_SEL:
      begin
        // Slow lands here one clock after the window match
        dev_d = 1'h1;
        oe_d  = 1'h1;
        if (rd_q)
        begin
          xfer_d = ready && !done_ph;
          trdy_d = (ready && rdy1_q) || stall;
          if (xfer_q && !stall)
          begin
            ad_d = bus.local_read_data;
          end
          ad_oe_d = ad_oe_q || trdy_d;
        end
        else
        begin
          trdy_d = ready || stall;
          xfer_d = !bus.irdyn && trdy_q && ready;
          if (xfer_d)
          begin
            wdat_d = bus.ad;
          end
        end
        if (done_ph)
        begin
          // Drive high for one clock before releasing
          st_d    = pcitgt_pkg::PCITGT_T_DONE;
          dev_d   = 1'h0;
          trdy_d  = 1'h0;
          win_d   = 1'h0;
          ad_oe_d = 1'h0;
        end
      end
      default:
      begin
        st_d = pcitgt_pkg::PCITGT_T_IDLE;
      end
    endcase
    if (fin)
    begin
      st_d    = pcitgt_pkg::PCITGT_T_DECODE;
      laddr_d = fa;
      sel_d   = win_match(fa, bus.cben);
      rd_d    = is_read(bus.cben);
      // Fast speed answers in the decode clock itself
      dev_d   = sel_d && fast;
      oe_d    = sel_d && fast;
      trdy_d  = 1'h0;
      win_d   = 1'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q    <= pcitgt_pkg::PCITGT_T_IDLE;
      frm_q   <= 1'h1;
      lo_q    <= `PCITGT_AD_RST;
      sel_q   <= 1'h0;
      rd_q    <= 1'h0;
      dev_q   <= 1'h0;
      trdy_q  <= 1'h0;
      xfer_q  <= 1'h0;
      rdy1_q  <= 1'h0;
      oe_q    <= 1'h0;
      ad_oe_q <= 1'h0;
      ad_q    <= `PCITGT_AD_RST;
      wdat_q  <= `PCITGT_AD_RST;
      laddr_q <= {`PCITGT_HI_ZERO, `PCITGT_AD_RST};
      win_q   <= 1'h0;
    end
    else
    begin
      st_q    <= st_d;
      frm_q   <= frm_d;
      lo_q    <= lo_d;
      sel_q   <= sel_d;
      rd_q    <= rd_d;
      dev_q   <= dev_d;
      trdy_q  <= trdy_d;
      xfer_q  <= xfer_d;
      rdy1_q  <= rdy1_d;
      oe_q    <= oe_d;
      ad_oe_q <= ad_oe_d;
      ad_q    <= ad_d;
      wdat_q  <= wdat_d;
      laddr_q <= laddr_d;
      win_q   <= win_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.t_devsel_n          = !dev_q;
  assign bus.t_trdy_n            = !trdy_q;
  assign bus.t_ctl_oe_n          = !oe_q;
  assign bus.t_ad                = ad_q;
  assign bus.t_ad_oe_n           = !ad_oe_q;
  assign bus.local_addr_out      = laddr_q;
  assign bus.win_hit             = win_q;
  assign bus.local_xfer_strobe_n = !xfer_q;
  assign bus.local_write_data    = wdat_q;

endmodule

// file: rtl/pcitgt_partner.sv
// Purpose: bus master plus back-end facing the target
// Assumes: single bus clock; commands are memory read or write
// Notes:   back-to-back only after a write, reads need turnaround
`timescale 1ns/1ps
`include "pcitgt_cfg.svh"
module pcitgt_partner
#(
  parameter int LEN_W = 8
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Command port
  input  wire logic             start_i,
  input  wire logic [63:0]      cmd_addr_i,
  input  wire logic             cmd_write_i,
  input  wire logic [LEN_W-1:0] cmd_len_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  abort_o,
  // Data port
  input  wire logic [31:0]      wr_data_i,
  output logic                  wr_take_o,
  output logic [31:0]           rd_data_o,
  output logic                  rd_valid_o,
  // Back-end port
  input  wire logic             be_ready_i,
  input  wire logic [31:0]      be_rdata_i,
  output logic [63:0]           be_addr_o,
  output logic                  be_hit_o,
  output logic                  be_xfer_o,
  output logic [31:0]           be_wdata_o,
  // Bus
  pcitgt_if.partner             bus
);

  if (LEN_W < 2)
  begin : g_chk
    $error("length field too narrow");
  end

  pcitgt_pkg::pcitgt_mstate_e st_q, st_d;
  logic             frame_q, frame_d;
  logic             irdy_q, irdy_d;
  logic             ctl_oe_q, ctl_oe_d;
  logic             iroe_q, iroe_d;
  logic             ad_oe_q, ad_oe_d;
  logic [31:0]      ad_q, ad_d;
  logic [3:0]       cbe_q, cbe_d;
  logic [31:0]      hi_q, hi_d;
  logic             wr_q, wr_d;
  logic [LEN_W-1:0] left_q, left_d;
  logic [2:0]       wait_q, wait_d;
  logic             dsel_q, dsel_d;
  logic [31:0]      rdd_q, rdd_d;
  logic             rdv_q, rdv_d;
  logic             done_q, done_d;
  logic             abt_q, abt_d;
  logic [31:0]      lrd_q;
  logic             take;
  logic             last;
  logic             cmpl;
  logic [3:0]       cmd;

  always_comb
  begin
    st_d     = st_q;
    frame_d  = frame_q;
    irdy_d   = irdy_q;
    ctl_oe_d = ctl_oe_q;
    iroe_d   = iroe_q;
    ad_oe_d  = ad_oe_q;
    ad_d     = ad_q;
    cbe_d    = cbe_q;
    hi_d     = hi_q;
    wr_d     = wr_q;
    left_d   = left_q;
    wait_d   = wait_q;
    dsel_d   = dsel_q;
    rdd_d    = rdd_q;
    rdv_d    = 1'h0;
    done_d   = 1'h0;
    abt_d    = 1'h0;
    wr_take_o = 1'h0;
    cmd  = wr_q ? `PCITGT_CMD_MWR : `PCITGT_CMD_MRD;
    cmpl = irdy_q && !bus.trdyn;
    last = 1'h0;
    case (st_q)
      pcitgt_pkg::PCITGT_M_ADDR:
      begin
        if (hi_q != `PCITGT_HI_ZERO)
        begin
          ad_d  = hi_q;
          cbe_d = cmd;
          st_d  = pcitgt_pkg::PCITGT_M_ADDR2;
        end
      end
      pcitgt_pkg::PCITGT_M_DATA:
      begin
        dsel_d = dsel_q || !bus.devseln;
        wait_d = (wait_q == `PCITGT_ABORT_CLK) ? wait_q : wait_q + 3'h1;
        if (cmpl)
        begin
          rdd_d = bus.ad;
          rdv_d = !wr_q;
          if (left_q == LEN_W'(1))
          begin
            last = 1'h1;
          end
          else
          begin
            left_d  = left_q - LEN_W'(1);
            frame_d = left_q != LEN_W'(2);
            if (wr_q)
            begin
              ad_d      = wr_data_i;
              wr_take_o = 1'h1;
            end
          end
        end
        else if (!dsel_q && wait_q == `PCITGT_ABORT_CLK)
        begin
          last  = 1'h1;
          abt_d = 1'h1;
        end
      end
      pcitgt_pkg::PCITGT_M_TURN:
      begin
        iroe_d = 1'h0;
        st_d   = pcitgt_pkg::PCITGT_M_IDLE;
      end
      default:
      begin
        st_d = st_q;
      end
    endcase
    if (last)
    begin
      st_d     = pcitgt_pkg::PCITGT_M_TURN;
      irdy_d   = 1'h0;
      frame_d  = 1'h0;
      ctl_oe_d = 1'h0;
      ad_oe_d  = 1'h0;
      done_d   = !abt_d;
    end
    // Back-to-back start in the clock after a final write phase
    take = start_i && (st_q == pcitgt_pkg::PCITGT_M_IDLE ||
           st_q == pcitgt_pkg::PCITGT_M_TURN || (last && wr_q));
    if (take)
    begin
      st_d     = pcitgt_pkg::PCITGT_M_ADDR;
      hi_d     = cmd_addr_i[63:32];
      wr_d     = cmd_write_i;
      left_d   = cmd_len_i;
      frame_d  = 1'h1;
      ctl_oe_d = 1'h1;
      ad_oe_d  = 1'h1;
      ad_d     = cmd_addr_i[31:0];
      cbe_d    = (cmd_addr_i[63:32] != `PCITGT_HI_ZERO) ?
                 `PCITGT_CMD_DAC :
                 (cmd_write_i ? `PCITGT_CMD_MWR : `PCITGT_CMD_MRD);
    end
    else if (st_q == pcitgt_pkg::PCITGT_M_ADDR2 ||
             (st_q == pcitgt_pkg::PCITGT_M_ADDR &&
              hi_q == `PCITGT_HI_ZERO))
    begin
      st_d    = pcitgt_pkg::PCITGT_M_DATA;
      cbe_d   = `PCITGT_BE_ALL;
      irdy_d  = 1'h1;
      iroe_d  = 1'h1;
      frame_d = left_q != LEN_W'(1);
      ad_oe_d = wr_q;
      wait_d  = 3'h0;
      dsel_d  = 1'h0;
      if (wr_q)
      begin
        ad_d      = wr_data_i;
        wr_take_o = 1'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q     <= pcitgt_pkg::PCITGT_M_IDLE;
      frame_q  <= 1'h0;
      irdy_q   <= 1'h0;
      ctl_oe_q <= 1'h0;
      iroe_q   <= 1'h0;
      ad_oe_q  <= 1'h0;
      ad_q     <= `PCITGT_AD_RST;
      cbe_q    <= `PCITGT_CBE_IDLE;
      hi_q     <= `PCITGT_HI_ZERO;
      wr_q     <= 1'h0;
      left_q   <= '0;
      wait_q   <= 3'h0;
      dsel_q   <= 1'h0;
      rdd_q    <= `PCITGT_AD_RST;
      rdv_q    <= 1'h0;
      done_q   <= 1'h0;
      abt_q    <= 1'h0;
      lrd_q    <= `PCITGT_AD_RST;
    end
    else
    begin
      st_q     <= st_d;
      frame_q  <= frame_d;
      irdy_q   <= irdy_d;
      ctl_oe_q <= ctl_oe_d;
      iroe_q   <= iroe_d;
      ad_oe_q  <= ad_oe_d;
      ad_q     <= ad_d;
      cbe_q    <= cbe_d;
      hi_q     <= hi_d;
      wr_q     <= wr_d;
      left_q   <= left_d;
      wait_q   <= wait_d;
      dsel_q   <= dsel_d;
      rdd_q    <= rdd_d;
      rdv_q    <= rdv_d;
      done_q   <= done_d;
      abt_q    <= abt_d;
      // Word presented now is on the bus during the next strobe
      lrd_q <= be_rdata_i;
    end
  end

  assign bus.m_frame_n       = !frame_q;
  assign bus.m_irdy_n        = !irdy_q;
  assign bus.m_cbe_n         = cbe_q;
  assign bus.m_ad            = ad_q;
  assign bus.m_ctl_oe_n      = !ctl_oe_q;
  assign bus.m_irdy_oe_n     = !iroe_q;
  assign bus.m_ad_oe_n       = !ad_oe_q;
  assign bus.backend_ready_n = !be_ready_i;
  assign bus.local_read_data = lrd_q;
  assign busy_o              = st_q != pcitgt_pkg::PCITGT_M_IDLE;
  assign done_o              = done_q;
  assign abort_o             = abt_q;
  assign rd_data_o           = rdd_q;
  assign rd_valid_o          = rdv_q;
  assign be_addr_o           = bus.local_addr_out;
  assign be_hit_o            = bus.win_hit;
  assign be_xfer_o           = !bus.local_xfer_strobe_n;
  assign be_wdata_o          = bus.local_write_data;

endmodule

// file: verif/pcitgt_asserts.sv
// Purpose: checks target timing on the shared bus wires
// Assumes: one clock, synchronous active-low reset
// Notes:   instantiated beside the interface by the bench
`timescale 1ns/1ps
module pcitgt_asserts
#(
  parameter logic [63:0] WIN_BASE = 64'h0000_0001_0000_0000,
  parameter logic [63:0] WIN_MASK = 64'hFFFF_FFFF_FFF0_0000
)
(
  // Clock, reset, speed
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire pcitgt_pkg::pcitgt_speed_e select_response_speed_i,
  // Bus lines
  input  wire logic                      framen,
  input  wire logic                      irdyn,
  input  wire logic [3:0]                cben,
  input  wire logic [31:0]               ad,
  input  wire logic                      devseln,
  input  wire logic                      trdyn,
  input  wire logic                      t_ctl_oe_n,
  input  wire logic                      t_ad_oe_n,
  // Back-end lines
  input  wire logic                      backend_ready_n,
  input  wire logic [63:0]               local_addr_out,
  input  wire logic                      win_hit,
  input  wire logic                      local_xfer_strobe_n
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic slow;
  logic fin;
  assign slow = select_response_speed_i == pcitgt_pkg::PCITGT_SPD_SLOW;
  // Final data phase: frame released while both ready strobes low
  assign fin  = framen && !irdyn && !trdyn;

  AST_ADDR_SAC: assert property ($fell(framen) && cben != 4'hD
    |=> local_addr_out == {32'h0000_0000, $past(ad)})
    else $error("single address not presented in decode clock");
  AST_ADDR_DAC: assert property ($fell(framen) && cben == 4'hD
    |=> ##1 local_addr_out == {$past(ad), $past(ad, 2)})
    else $error("dual address not presented in decode clock");
  AST_HIT_MATCH: assert property ($rose(win_hit)
    |-> (local_addr_out & WIN_MASK) == WIN_BASE)
    else $error("window match without address match");
  AST_DEV_SLOW: assert property (slow && $rose(win_hit)
    |-> devseln ##1 !devseln)
    else $error("slow select not one clock after match");
  AST_DEV_EARLY: assert property (!slow && $rose(win_hit)
    |-> !devseln)
    else $error("fast or medium select late");
  AST_STROBE: assert property ($fell(local_xfer_strobe_n)
    |-> !$past(backend_ready_n))
    else $error("strobe without prior back-end ready");
  AST_RD_TRDY: assert property (!trdyn && !t_ad_oe_n
    |-> !$past(backend_ready_n) && !$past(backend_ready_n, 2))
    else $error("read data phase without two ready clocks");
  AST_WR_TRDY: assert property (!trdyn && t_ad_oe_n
    |-> !$past(backend_ready_n))
    else $error("write data phase without ready");
  AST_RELEASE: assert property (fin
    |=> trdyn && devseln && !win_hit && t_ad_oe_n)
    else $error("target not released after final phase");
  AST_FLOAT: assert property (fin && select_response_speed_i !=
    pcitgt_pkg::PCITGT_SPD_FAST |=> ##1 t_ctl_oe_n)
    else $error("select and ready not floated in idle clock");
endmodule

// file: verif/pcitgt_tb.sv
// Purpose: drives partner commands and back-end, judges results
// Assumes: target window at its default parameters
// Notes:   speed changes only while the bus is idle
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module pci_target_dac_fast_b2b_tb;
  localparam logic [63:0] A_RD = 64'h0000_0001_0000_0100;
  localparam logic [63:0] A_WR = 64'h0000_0001_0000_0800;
  localparam logic [63:0] A_MH = 64'h0000_0002_0000_0040;
  localparam logic [63:0] A_ML = 64'h0000_0000_0000_1000;
  logic                      clk_i;
  logic                      rst_n_i;
  logic                      start_i;
  logic [63:0]               cmd_addr_i;
  logic                      cmd_write_i;
  logic [7:0]                cmd_len_i;
  logic [31:0]               wr_data_i;
  logic                      wr_take_o;
  logic [31:0]               rd_data_o;
  logic                      rd_valid_o;
  logic                      done_o;
  logic                      abort_o;
  logic                      be_ready_i;
  logic [31:0]               be_rdata_i;
  logic                      be_hit_o;
  logic                      busy_o;
  logic [63:0]               be_addr_o;
  logic [31:0]               rd_word;
  logic                      took = 1'h0;
  logic                      wr_mode;
  pcitgt_pkg::pcitgt_speed_e speed;
  int failures = 0;
  int n_compared = 0;
  int n_done = 0;
  int n_abort = 0;
  int n_hit = 0;
  int wr_seen = 0;
  int rd_seen = 0;
  int wr_idx = 0;

  pcitgt_if bus_if ();
  pcitgt_target u_pcitgt_target
  (
    .clk_i                   (clk_i),
    .rst_n_i                 (rst_n_i),
    .select_response_speed_i (speed),
    .bus                     (bus_if)
  );
  pcitgt_partner u_pcitgt_partner
  (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (start_i),
    .cmd_addr_i  (cmd_addr_i),
    .cmd_write_i (cmd_write_i),
    .cmd_len_i   (cmd_len_i),
    .busy_o      (busy_o),
    .done_o      (done_o),
    .abort_o     (abort_o),
    .wr_data_i   (wr_data_i),
    .wr_take_o   (wr_take_o),
    .rd_data_o   (rd_data_o),
    .rd_valid_o  (rd_valid_o),
    .be_ready_i  (be_ready_i),
    .be_rdata_i  (be_rdata_i),
    .be_addr_o   (be_addr_o),
    .be_hit_o    (be_hit_o),
    .be_xfer_o   (),
    .be_wdata_o  (),
    .bus         (bus_if)
  );
  pcitgt_asserts u_pcitgt_asserts
  (
    .clk_i                   (clk_i),
    .rst_n_i                 (rst_n_i),
    .select_response_speed_i (speed),
    .framen                  (bus_if.framen),
    .irdyn                   (bus_if.irdyn),
    .cben                    (bus_if.cben),
    .ad                      (bus_if.ad),
    .devseln                 (bus_if.devseln),
    .trdyn                   (bus_if.trdyn),
    .t_ctl_oe_n              (bus_if.t_ctl_oe_n),
    .t_ad_oe_n               (bus_if.t_ad_oe_n),
    .backend_ready_n         (bus_if.backend_ready_n),
    .local_addr_out          (bus_if.local_addr_out),
    .win_hit                 (bus_if.win_hit),
    .local_xfer_strobe_n     (bus_if.local_xfer_strobe_n)
  );

  // ---------------------------------------------------------------
  // Clock and monitors
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    took <= wr_take_o;
    if (done_o === 1'h1) n_done++;
    if (abort_o === 1'h1) n_abort++;
    if (be_hit_o === 1'h1) n_hit++;
    if (rd_valid_o === 1'h1)
    begin
      `CHK(rd_data_o, rd_word)
      rd_seen++;
    end
    if (wr_mode && bus_if.local_xfer_strobe_n === 1'h0)
    begin
      `CHK(bus_if.local_write_data, 32'hC0DE_0000 + 32'(wr_seen))
      wr_seen++;
    end
  end

  // Next write word appears only after the previous one was taken
  always @(negedge clk_i)
    if (took)
      wr_idx++;
  assign wr_data_i = 32'hC0DE_0000 + 32'(wr_idx);

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic run(input logic [63:0] a, input logic w,
                     input logic [7:0] len);
    int n;
    int k;
    begin
      k = n_done + n_abort;
      @(negedge clk_i);
      cmd_addr_i  = a;
      cmd_write_i = w;
      cmd_len_i   = len;
      start_i     = 1'h1;
      @(negedge clk_i);
      start_i = 1'h0;
      n = 0;
      while (n_done + n_abort == k && n < 200)
      begin
        @(negedge clk_i);
        n++;
      end
      repeat (2) @(negedge clk_i);
      `CHK(busy_o, 1'h0)
    end
  endtask

  task automatic t_reads();
    int r0;
    int d0;
    begin
      for (int s = 0; s < 3; s++)
      begin
        r0         = rd_seen;
        d0         = n_done;
        speed      = pcitgt_pkg::pcitgt_speed_e'(s);
        rd_word    = 32'h5A00_0000 + 32'(s);
        be_rdata_i = rd_word;
        run(A_RD, 1'h0, 8'h03);
        `CHK(n_done - d0, 1)
        `CHK(rd_seen - r0, 3)
        `CHK(bus_if.t_ctl_oe_n, 1'h1)
        `CHK(be_hit_o, 1'h0)
        `CHK(be_addr_o, A_RD)
      end
      $display("test dual address reads done");
    end
  endtask

  task automatic t_b2b();
    int d0;
    int n;
    begin
      d0         = n_done;
      n          = 0;
      wr_mode    = 1'h1;
      be_ready_i = 1'h0;
      speed      = pcitgt_pkg::PCITGT_SPD_SLOW;
      @(negedge clk_i);
      cmd_addr_i  = A_WR;
      cmd_write_i = 1'h1;
      cmd_len_i   = 8'h02;
      start_i     = 1'h1;
      // Start stays up: each next command is taken in a final phase
      repeat (8) @(negedge clk_i);
      be_ready_i = 1'h1;
      for (int j = 0; j < 2; j++)
      begin
        while (!(bus_if.framen && !bus_if.irdyn && !bus_if.trdyn) && n < 100)
        begin
          @(negedge clk_i);
          n++;
        end
        @(negedge clk_i);
        cmd_addr_i = A_WR + 64'h0000_0000_0000_0040;
        cmd_len_i  = 8'h01;
      end
      start_i = 1'h0;
      while (n_done - d0 < 3 && n < 300)
      begin
        @(negedge clk_i);
        n++;
      end
      repeat (2) @(negedge clk_i);
      `CHK(n_done - d0, 3)
      `CHK(wr_seen, 5)
      `CHK(be_addr_o, A_WR + 64'h0000_0000_0000_0040)
      wr_mode = 1'h0;
      $display("test back-to-back writes done");
    end
  endtask

  task automatic t_miss();
    int a0;
    int h0;
    begin
      for (int i = 0; i < 2; i++)
      begin
        a0 = n_abort;
        h0 = n_hit;
        run(i == 0 ? A_MH : A_ML, 1'h0, 8'h01);
        `CHK(n_abort - a0, 1)
        `CHK(n_hit - h0, 0)
      end
      $display("test window misses done");
    end
  endtask

  task automatic give_verdict();
    begin
      $display("counts compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial
  begin
    rst_n_i     = 1'h0;
    start_i     = 1'h0;
    cmd_addr_i  = 64'h0000_0000_0000_0000;
    cmd_write_i = 1'h0;
    cmd_len_i   = 8'h01;
    be_ready_i  = 1'h1;
    be_rdata_i  = 32'h0000_0000;
    rd_word     = 32'h0000_0000;
    wr_mode     = 1'h0;
    speed       = pcitgt_pkg::PCITGT_SPD_SLOW;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'h1;
    t_reads();
    t_b2b();
    t_miss();
    give_verdict();
  end

  // Tests need well under a thousand clocks; this allows ample slack
  initial
  begin
    #20000;
    failures++;
    give_verdict();
  end
endmodule
